/* File: src/pol_fault_pkg.sv */
package pol_fault_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_SETPT   = 8'h04;
   localparam logic [7:0] ADDR_MEAS    = 8'h08;
   localparam logic [7:0] ADDR_STATUS  = 8'h0c;
   localparam logic [7:0] ADDR_IRQ     = 8'h10;
   localparam logic [7:0] ADDR_MASK    = 8'h14;

   // ----------------------------------------------------------------
   // ctrl fields
   // ----------------------------------------------------------------
   localparam int CTRL_ENABLE     = 0;
   localparam int CTRL_UV_SEL     = 1;   // 2 bits: 0=75 1=80 2=85 percent
   localparam int CTRL_PG_SEL     = 3;   // 0=90 1=95 percent
   localparam int CTRL_OV_SEL     = 4;   // 2 bits: 0=110 1=120 2=130 percent
   localparam int CTRL_TRK_EN     = 6;
   localparam int CTRL_UV_LATCH   = 7;
   localparam int CTRL_OT_LATCH   = 8;
   localparam int CTRL_TRK_LATCH  = 9;
   localparam int CTRL_OV_LATCH   = 10;
   localparam int CTRL_RAMPING    = 11;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0020;  // ov default 130 percent

   // ----------------------------------------------------------------
   // thresholds: voltages in millivolts, temperatures in degrees c
   // ----------------------------------------------------------------
   localparam int UV_PCT_BASE   = 75;
   localparam int UV_PCT_STEP   = 5;
   localparam int UV_PCT_MAX    = 85;
   localparam int PG_PCT_LOW    = 90;
   localparam int PG_PCT_STEP   = 5;
   localparam int PG_PCT_HIGH   = 110;
   localparam int OV_PCT_BASE   = 110;
   localparam int OV_PCT_STEP   = 10;
   localparam int OV_PCT_MAX    = 130;
   localparam int OV_MIN_MV     = 1000;
   localparam int TRK_ERR_MV    = 250;
   localparam int OT_OFF_C      = 130;
   localparam int OT_ON_C       = 120;
   localparam int WARN_SET_C    = 120;
   localparam int WARN_HYST_C   = 3;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ       = 40;
   localparam int DELAY_US      = 6;
   localparam int DELAY_CYC     = DELAY_US * CLK_MHZ;
   localparam int RETRY_MS      = 130;
   localparam int RETRY_CYC     = RETRY_MS * 1000 * CLK_MHZ;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] vout_mv;
      logic signed [15:0] ramp_err_mv;
      logic signed [11:0] temp_c;
   } meas_t;

   typedef struct packed {
      logic ov;
      logic trk;
      logic ot;
      logic uv;
   } fault_t;

   typedef enum logic [2:0] {
      ST_OFF   = 3'b001,
      ST_RUN   = 3'b010,
      ST_FAULT = 3'b100
   } pstate_t;

endpackage

/* File: src/pol_fault_protection_monitor.sv */
`timescale 1ns/1ps
// What this block does
// R01: undervoltage threshold 75, 80 or 85 percent of setpoint
// R02: any protection trip issues turn-off 6 us after crossing
// R03: overtemperature off at 130 C, retry allowed only at 120 C, restart after reconfigure below 130 C
// R04: tracking off by default, ramp only, 250 mV, latching or retry
// R05: warning always active, sets at 120 C, clears 3 C lower
// R06: warning indication asserts 6 us after crossing
// R07: power good high inside 90/95 to 110 percent window
// R08: power good changes 6 us after a window crossing
// R09: overvoltage threshold never below 1.0 V
// R10: overvoltage 110, 120 or 130 percent, default 130
// R11: latching holds off until reconfigure; else retry after 130 ms
// R12: each protection has its own fault flag captured at turn-off
module pol_fault_protection_monitor import pol_fault_pkg::*; #(
   parameter int DELAY_CYCLES = DELAY_CYC,
   parameter int RETRY_CYCLES = RETRY_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic output_on,
   output logic power_good_output,
   output logic irq
);

   // ----------------------------------------------------------------
   // registers and bus
   // ----------------------------------------------------------------
   logic [31:0] ctrl_q, ctrl_d;
   logic [15:0] setpt_q, setpt_d;
   meas_t meas_q, meas_d;
   logic [4:0] irq_q, irq_d, mask_q, mask_d;
   fault_t flag_q, flag_d;
   logic warn_q, warn_d;
   logic pg_q, pg_d;
   pstate_t st_q, st_d;
   logic [31:0] retry_q, retry_d;
   logic [31:0] rdata_d;
   logic wr, rd, addr_ok;

   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign pready = 1'b1;
   assign addr_ok = paddr inside {ADDR_CTRL, ADDR_SETPT, ADDR_MEAS, ADDR_STATUS, ADDR_IRQ, ADDR_MASK};
   assign pslverr = psel & penable & ~addr_ok;

   function automatic logic [31:0] pct(input logic [15:0] mv, input int p);
      pct = (32'(mv) * 32'(p)) / 32'd100;
   endfunction

   // ----------------------------------------------------------------
   // threshold computation
   // ----------------------------------------------------------------
   logic [31:0] uv_th, pg_lo, pg_hi, ov_th, ov_raw;
   int uv_p, ov_p;
   always_comb begin
      uv_p = UV_PCT_BASE + UV_PCT_STEP * int'(ctrl_q[CTRL_UV_SEL +: 2]);
      if (uv_p > UV_PCT_MAX) uv_p = UV_PCT_MAX;
      uv_th = pct(setpt_q, uv_p); // R01
      pg_lo = pct(setpt_q, ctrl_q[CTRL_PG_SEL] ? PG_PCT_LOW + PG_PCT_STEP : PG_PCT_LOW); // R07
      pg_hi = pct(setpt_q, PG_PCT_HIGH); // R07
      ov_p = OV_PCT_BASE + OV_PCT_STEP * int'(ctrl_q[CTRL_OV_SEL +: 2]);
      if (ov_p > OV_PCT_MAX) ov_p = OV_PCT_MAX; // R10
      ov_raw = pct(setpt_q, ov_p);
      ov_th = (ov_raw < 32'(OV_MIN_MV)) ? 32'(OV_MIN_MV) : ov_raw; // R09
   end

   // ----------------------------------------------------------------
   // raw comparisons
   // ----------------------------------------------------------------
   logic raw_uv, raw_ov, raw_ot, raw_trk, raw_win, warn_raw;
   always_comb begin
      raw_uv = (st_q == ST_RUN) && !ctrl_q[CTRL_RAMPING] && (32'(meas_q.vout_mv) < uv_th);
      raw_ov = (st_q == ST_RUN) && (32'(meas_q.vout_mv) > ov_th);
      // signed readings are widened to int so that a negative value never compares as a huge one
      raw_ot = int'(meas_q.temp_c) >= OT_OFF_C; // R03
      raw_trk = (st_q == ST_RUN) && ctrl_q[CTRL_TRK_EN] && ctrl_q[CTRL_RAMPING] && // R04
                ((int'(meas_q.ramp_err_mv) > TRK_ERR_MV) || (int'(meas_q.ramp_err_mv) < -TRK_ERR_MV));
      raw_win = (32'(meas_q.vout_mv) >= pg_lo) && (32'(meas_q.vout_mv) <= pg_hi) && (st_q == ST_RUN);
      // hysteresis: set at the warning level, clear 3 degrees below it
      if (warn_q) warn_raw = int'(meas_q.temp_c) > WARN_SET_C - WARN_HYST_C; // R05
      else warn_raw = int'(meas_q.temp_c) >= WARN_SET_C; // R05
   end

   // ----------------------------------------------------------------
   // 6 us qualification: a condition must hold the full delay to act
   // ----------------------------------------------------------------
   localparam int NQ = 6;
   logic [NQ-1:0] qin, qout;
   logic [NQ-1:0][15:0] qcnt_q, qcnt_d;
   assign qin = {raw_win != pg_q, warn_raw != warn_q, raw_ov, raw_trk, raw_ot, raw_uv};
   always_comb begin
      for (int i = 0; i < NQ; i++) begin
         qcnt_d[i] = qin[i] ? ((qcnt_q[i] == 16'(DELAY_CYCLES)) ? qcnt_q[i] : qcnt_q[i] + 16'd1) : 16'd0;
         qout[i] = qin[i] && (qcnt_q[i] == 16'(DELAY_CYCLES - 1)); // R02 R06 R08
      end
   end

   // ----------------------------------------------------------------
   // protection state machine
   // ----------------------------------------------------------------
   fault_t trip;
   logic latch_any, cfg_wr;
   assign trip = '{ov: qout[3], trk: qout[2], ot: qout[1], uv: qout[0]};
   assign cfg_wr = wr && (paddr == ADDR_CTRL);
   always_comb begin
      st_d = st_q;
      retry_d = retry_q;
      flag_d = flag_q;
      latch_any = (trip.uv & ctrl_q[CTRL_UV_LATCH]) | (trip.ot & ctrl_q[CTRL_OT_LATCH]) |
                  (trip.trk & ctrl_q[CTRL_TRK_LATCH]) | (trip.ov & ctrl_q[CTRL_OV_LATCH]);
      case (st_q)
         ST_OFF: begin
            if (ctrl_q[CTRL_ENABLE] && !raw_ot) st_d = ST_RUN;
         end
         ST_RUN: begin
            if (!ctrl_q[CTRL_ENABLE]) begin
               st_d = ST_OFF;
            end else if (|trip) begin // R02
               st_d = ST_FAULT;
               flag_d = flag_q | trip; // R12
               retry_d = latch_any ? '1 : 32'(RETRY_CYCLES); // R11
            end
         end
         ST_FAULT: begin
            if (cfg_wr) begin // R11
               st_d = ST_OFF;
               flag_d = '0;
            end else if (retry_q != '1 && retry_q != 32'd0) begin
               retry_d = retry_q - 32'd1;
            end else if (retry_q == 32'd0 && int'(meas_q.temp_c) <= OT_ON_C) begin // R03 R11
               st_d = ST_RUN;
            end
         end
         default: st_d = ST_OFF;
      endcase
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   logic setpt_wr, meas_wr, mask_wr, irq_rd, setup;
   logic [31:0] rd_word, rdata_q;
   assign setpt_wr = wr && (paddr == ADDR_SETPT);
   assign meas_wr = wr && (paddr == ADDR_MEAS);
   assign mask_wr = wr && (paddr == ADDR_MASK);
   assign irq_rd = rd && (paddr == ADDR_IRQ);
   assign setup = psel & ~penable;

   always_comb begin
      ctrl_d = cfg_wr ? pwdata : ctrl_q;
      setpt_d = setpt_wr ? pwdata[15:0] : setpt_q; // R01 R07
      mask_d = mask_wr ? pwdata[4:0] : mask_q;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RESET;
         setpt_q <= 16'h0;
         mask_q <= 5'h0;
      end else begin
         ctrl_q <= ctrl_d;
         setpt_q <= setpt_d;
         mask_q <= mask_d;
      end
   end

   // ----------------------------------------------------------------
   // measurements
   // ----------------------------------------------------------------
   // the three readings need 44 bits, so vout rides in the upper half
   // of the setpoint word and the meas word carries ramp error and temp
   always_comb begin
      meas_d = meas_q;
      if (setpt_wr) begin
         meas_d.vout_mv = pwdata[31:16];
      end
      if (meas_wr) begin
         meas_d.ramp_err_mv = pwdata[27:12];
         meas_d.temp_c = pwdata[11:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meas_q <= '0;
      end else begin
         meas_q <= meas_d;
      end
   end

   // ----------------------------------------------------------------
   // qualification counters
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qcnt_q <= '0;
      end else begin
         qcnt_q <= qcnt_d;
      end
   end

   // ----------------------------------------------------------------
   // protection state
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_OFF;
         retry_q <= 32'h0;
         flag_q <= '0;
      end else begin
         st_q <= st_d;
         retry_q <= retry_d;
         flag_q <= flag_d;
      end
   end

   // ----------------------------------------------------------------
   // warning and power good indications
   // ----------------------------------------------------------------
   // both toggle only after the new level has held the full delay, so
   // a reading that dithers across a bound leaves them still
   always_comb begin
      warn_d = qout[4] ? ~warn_q : warn_q; // R05 R06
      pg_d = qout[5] ? ~pg_q : pg_q; // R08
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         warn_q <= 1'b0;
         pg_q <= 1'b0;
      end else begin
         warn_q <= warn_d;
         pg_q <= pg_d;
      end
   end

   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------
   // a read clears only the bits it returned: an event landing between
   // setup and access stays pending, and a set in the access cycle wins
   always_comb begin
      irq_d = irq_rd ? (irq_q & ~rdata_q[4:0]) : irq_q;
      irq_d = irq_d | {qout[4] & ~warn_q, trip}; // R05 R12
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 5'h0;
      end else begin
         irq_q <= irq_d;
      end
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   // the word is captured in the setup cycle, so prdata comes from a
   // flop and still stands in the zero-wait access cycle
   always_comb begin
      case (paddr)
         ADDR_CTRL: rd_word = ctrl_q;
         ADDR_SETPT: rd_word = {meas_q.vout_mv, setpt_q};
         ADDR_MEAS: rd_word = {4'h0, meas_q.ramp_err_mv, meas_q.temp_c};
         ADDR_STATUS: rd_word = {24'h0, st_q == ST_RUN, pg_q, warn_q, 1'b0, flag_q}; // R05 R12
         ADDR_IRQ: rd_word = {27'h0, irq_q};
         ADDR_MASK: rd_word = {27'h0, mask_q};
         default: rd_word = 32'h0;
      endcase
      rdata_d = setup ? rd_word : rdata_q;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign prdata = rdata_q;
   assign output_on = (st_q == ST_RUN);
   assign power_good_output = pg_q; // R07
   assign irq = |(irq_q & mask_q);

endmodule

/* File: dv/pol_fault_monitor_asserts.sv */
`timescale 1ns/1ps
module pol_fault_monitor_asserts import pol_fault_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic output_on,
   input wire logic power_good_output,
   input wire logic irq
);
   logic acc;
   logic ctrl_wr;
   logic en_d;
   logic en_q;
   logic msk_d;
   logic msk_q;
   assign acc = psel && penable;
   assign ctrl_wr = acc && pwrite && paddr == ADDR_CTRL;
   always_comb begin
      en_d = ctrl_wr ? pwdata[CTRL_ENABLE] : en_q;
      msk_d = (acc && pwrite && paddr == ADDR_MASK) ? |pwdata[4:0] : msk_q;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= 1'b0;
         msk_q <= 1'b0;
      end else begin
         en_q <= en_d;
         msk_q <= msk_d;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // a fall right after a ctrl write is a reconfiguration, not a trip
   sequence s_trip_fall;
      $fell(output_on) && en_q && !$past(ctrl_wr) && !$past(ctrl_wr, 2);
   endsequence
   sequence s_held_off;
      !output_on [*8];
   endsequence
   ready_high_a: assert property (pready) else $error("pready low");
   slverr_map_a: assert property (acc && paddr[1:0] == 2'b00 |-> pslverr == (paddr > ADDR_MASK))
      else $error("pslverr wrong for address");
   slverr_idle_a: assert property (!acc |-> !pslverr) else $error("pslverr outside access");
   unmapped_rd_a: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   irq_masked_a: assert property (!msk_q && !$past(msk_q) |-> !irq) else $error("irq with empty mask");
   rise_enabled_a: assert property ($rose(output_on) |-> en_q) else $error("output on while disabled");
   trip_hold_a: assert property (s_trip_fall |=> s_held_off) else $error("restart too soon");
   disable_off_a: assert property (ctrl_wr && !pwdata[CTRL_ENABLE] |-> ##[1:2] !output_on)
      else $error("disable ignored");
endmodule
bind pol_fault_protection_monitor pol_fault_monitor_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .output_on(output_on), .power_good_output(power_good_output), .irq(irq));

/* File: dv/pg_reader.sv */
`timescale 1ns/1ps
// system side sampling power good into its own flop
module pg_reader (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic power_good_output,
   output logic pg_q
);
   logic pg_d;
   always_comb pg_d = power_good_output;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pg_q <= 1'b0;
      end else begin
         pg_q <= pg_d;
      end
   end
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb import pol_fault_pkg::*;;
   typedef struct {logic [7:0] a; logic [31:0] d; int w; logic [7:0] ra; logic [31:0] m; logic [31:0] e;} row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, output_on, power_good_output, irq, pg_q, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int n_mismatch = 0;
   int samples_checked = 0;
   // ----------------------------------------------------------------
   // rows: write, wait, read back masked; vout stays 0, setpoint 0 until the last two
   // ----------------------------------------------------------------
   row_t rows[16] = '{
      '{ADDR_MEAS, 32'h19, 2, ADDR_MASK, 32'hffffffff, 32'h0}, '{ADDR_MEAS, 32'h78, 12, ADDR_STATUS, 32'h20, 32'h20},
      '{ADDR_MEAS, 32'h76, 12, ADDR_STATUS, 32'h20, 32'h20}, '{ADDR_MEAS, 32'h74, 12, ADDR_STATUS, 32'h20, 32'h0},
      '{ADDR_CTRL, 32'h21, 4, ADDR_STATUS, 32'h80, 32'h80}, '{ADDR_MEAS, 32'h82, 14, ADDR_STATUS, 32'h82, 32'h2},
      '{ADDR_MEAS, 32'h7d, 60, ADDR_STATUS, 32'h80, 32'h0}, '{ADDR_MEAS, 32'h78, 60, ADDR_STATUS, 32'hc0, 32'hc0},
      '{ADDR_MEAS, 32'hc8019, 2, ADDR_STATUS, 32'h80, 32'h80}, '{ADDR_CTRL, 32'h861, 14, ADDR_STATUS, 32'h80, 32'h80},
      '{ADDR_MEAS, 32'h12c019, 14, ADDR_STATUS, 32'h84, 32'h4}, '{ADDR_CTRL, 32'ha61, 80, ADDR_STATUS, 32'h80, 32'h0},
      '{ADDR_CTRL, 32'h21, 4, ADDR_STATUS, 32'h80, 32'h80}, '{ADDR_CTRL, 32'h61, 14, ADDR_STATUS, 32'h80, 32'h80},
      '{ADDR_SETPT, 32'h3e8, 14, ADDR_STATUS, 32'h41, 32'h1}, '{ADDR_CTRL, 32'ha1, 80, ADDR_STATUS, 32'h80, 32'h0}};
   // short counts keep the retry cases inside a few hundred cycles
   pol_fault_protection_monitor #(.DELAY_CYCLES(10), .RETRY_CYCLES(50)) u_pol_fault_protection_monitor (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .output_on(output_on),
      .power_good_output(power_good_output), .irq(irq));
   pg_reader u_pg_reader (.pclk(pclk), .presetn(presetn), .power_good_output(power_good_output), .pg_q(pg_q));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   initial begin
      repeat (5000) @(posedge pclk);
      n_mismatch++;
      final_report;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (20) @(posedge pclk);
      chk({output_on, irq, power_good_output, pready}, 4'h1);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
      chk(rd, CTRL_RESET);
      apb(1'b0, 8'h18, 32'h0, rd, err);
      chk(rd, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("reset test done");
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d, rd, err);
         repeat (rows[i].w) @(posedge pclk);
         apb(1'b0, rows[i].ra, 32'h0, rd, err);
         chk(rd & rows[i].m, rows[i].e);
         $display("row %0d done", i);
      end
      chk({31'h0, pg_q}, 32'h0);
      apb(1'b1, ADDR_MASK, 32'h10, rd, err);
      chk({31'h0, irq}, 32'h1);
      apb(1'b0, ADDR_IRQ, 32'h0, rd, err);
      chk(rd & 32'h10, 32'h10);
      apb(1'b0, ADDR_IRQ, 32'h0, rd, err);
      chk(rd & 32'h10, 32'h0);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h20, rd, err);
      repeat (3) @(posedge pclk);
      chk({31'h0, output_on}, 32'h0);
      $display("irq test done");
      apb(1'b1, ADDR_CTRL, 32'h21, rd, err);
      apb(1'b1, ADDR_SETPT, 32'h03e8_03e8, rd, err);
      repeat (14) @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
      chk(rd & 32'hc8, 32'hc0);
      chk({31'h0, power_good_output}, 32'h1);
      apb(1'b1, ADDR_SETPT, 32'h0320_01f4, rd, err);
      repeat (14) @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
      chk(rd & 32'hc8, 32'h80);
      apb(1'b1, ADDR_SETPT, 32'h044c_01f4, rd, err);
      repeat (14) @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
      chk(rd & 32'h88, 32'h08);
      $display("overvoltage test done");
      final_report;
   end
endmodule
